// ---- design/sbsc_bank.sv ----
// State and timer of one SDRAM bank
`timescale 1ns/1ps
`default_nettype none
module sbsc_bank (
	// Link clock and reset
	input wire logic link_clk,
	input wire logic rst_n,
	// Accepted command aimed at this bank
	input wire logic cmd_en,
	input wire sbsc_pkg::sbsc_cmd_type cmd,
	input wire logic auto_pre,
	input wire logic pre_all,
	// State and legality
	output sbsc_pkg::sbsc_bank_type state_q,
	output logic cmd_ok,
	output logic pre_ok
);
	import sbsc_pkg::*;

	sbsc_bank_type state_d;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	wire done = (tmr_q == TMR_ZERO);
	wire is_rd = (cmd == CMD_RD);
	wire is_wr = (cmd == CMD_WR);
	wire is_pre = (cmd == CMD_PRE);
	wire burst_end = (state_q == BK_READ || state_q == BK_WRITE) && done;

	// Precharge allowed from idle or from open rows with no burst running
	assign pre_ok = (state_q == BK_IDLE) || (state_q == BK_ACTIVE) || burst_end;
	// Commands that this bank's state accepts
	assign cmd_ok = (state_q == BK_IDLE) ? (cmd == CMD_ACT || is_pre) :
		(state_q == BK_ACTIVE) ? (is_rd || is_wr || is_pre) :
		(state_q == BK_READ) ? (is_rd || ((is_wr || is_pre) && done)) :
		(state_q == BK_WRITE) ? (is_rd || is_wr || (is_pre && done)) :
		1'b0;

	// Next state and timer
	always_comb
	begin
		state_d = state_q;
		tmr_d = done ? tmr_q : tmr_q - 8'h01;
		unique case (state_q)
			BK_IDLE:
				if (cmd_en && cmd == CMD_ACT)
				begin
					state_d = BK_ACTIVATING;
					tmr_d = RCD_CYC - 8'h01;
				end
			BK_ACTIVATING:
				if (done)
					state_d = BK_ACTIVE;
			BK_ACTIVE, BK_READ, BK_WRITE:
				if (cmd_en && is_rd)
				begin
					state_d = auto_pre ? BK_READ_AP : BK_READ;
					tmr_d = BURST_CYC - 8'h01;
				end
				else if (cmd_en && is_wr)
				begin
					state_d = auto_pre ? BK_WRITE_AP : BK_WRITE;
					tmr_d = auto_pre ? WBURST_CYC + WR_CYC - 8'h01 : WBURST_CYC - 8'h01;
				end
				else if (cmd_en && is_pre)
				begin
					state_d = BK_PRECHARGING;
					tmr_d = RP_CYC - 8'h01;
				end
				else if (state_q != BK_ACTIVE && done)
					state_d = BK_ACTIVE;
			BK_READ_AP, BK_WRITE_AP:
				if (done)
				begin
					state_d = BK_PRECHARGING;
					tmr_d = RP_CYC - 8'h01;
				end
			BK_PRECHARGING:
				if (done)
					state_d = BK_IDLE;
		endcase
		if (pre_all)
		begin
			state_d = BK_IDLE;
			tmr_d = TMR_ZERO;
		end
	end

	// State and timer registers
	always_ff @(posedge link_clk)
	begin
		if (!rst_n)
		begin
			state_q <= BK_IDLE;
			tmr_q <= TMR_ZERO;
		end
		else
		begin
			state_q <= state_d;
			tmr_q <= tmr_d;
		end
	end

	// =========================================================
	// Checks
	act_to_open_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		state_q == BK_IDLE && cmd_en && cmd == CMD_ACT && !pre_all
		|=> state_q == BK_ACTIVATING [*2] ##1 state_q == BK_ACTIVE)
		else $error("activate did not open the row after the delay");
	pre_to_idle_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		state_q == BK_ACTIVE && cmd_en && is_pre && !pre_all
		|=> state_q == BK_PRECHARGING [*2] ##1 state_q == BK_IDLE)
		else $error("precharge did not idle the bank after the delay");
	ap_read_seq_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		state_q == BK_ACTIVE && cmd_en && is_rd && auto_pre && !pre_all
		|=> state_q == BK_READ_AP [*4] ##1 state_q == BK_PRECHARGING [*2] ##1 state_q == BK_IDLE)
		else $error("read with auto precharge sequence broken");
	rd_no_ap_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		state_q == BK_ACTIVE && cmd_en && is_rd && !auto_pre && !pre_all
		|=> state_q == BK_READ)
		else $error("read without auto precharge missed the read state");
	wr_ap_seq_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		state_q == BK_ACTIVE && cmd_en && is_wr && auto_pre && !pre_all
		|=> state_q == BK_WRITE_AP [*8] ##1 state_q == BK_WRITE_AP ##1
		state_q == BK_PRECHARGING [*2] ##1 state_q == BK_IDLE)
		else $error("write with auto precharge sequence broken");
	burst_end_a: assert property (@(posedge link_clk) disable iff (!rst_n)
		state_q == BK_WRITE && done && !cmd_en && !pre_all |=> state_q == BK_ACTIVE)
		else $error("write burst did not return to row active");

endmodule : sbsc_bank
`default_nettype wire

// ---- design/sbsc_pkg.sv ----
// Shared constants and types for the SDRAM bank state tracker
`default_nettype none
package sbsc_pkg;

	// =========================================================
	// Geometry and link clock
	localparam int NUM_BANKS = 8;
	localparam int BA_W = 3;
	localparam int TMR_W = 8;
	localparam int LINK_PERIOD_PS = 15000;

	// =========================================================
	// Timing in nanoseconds, write latency in clock cycles, burst length in beats (two per cycle)
	localparam int T_RP_NS = 20;
	localparam int T_RCD_NS = 20;
	localparam int T_RC_NS = 60;
	localparam int T_MRD_NS = 10;
	localparam int T_WR_NS = 20;
	localparam int T_XSNR_NS = 200;
	localparam int WL_CYC = 3;
	localparam int BL = 8;

	// Least time rounded up to whole cycles, at least one
	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : ns2cyc

	localparam logic [TMR_W-1:0] RP_CYC = TMR_W'(ns2cyc(T_RP_NS));
	localparam logic [TMR_W-1:0] RCD_CYC = TMR_W'(ns2cyc(T_RCD_NS));
	localparam logic [TMR_W-1:0] RC_CYC = TMR_W'(ns2cyc(T_RC_NS));
	localparam logic [TMR_W-1:0] MRD_CYC = TMR_W'(ns2cyc(T_MRD_NS));
	localparam logic [TMR_W-1:0] WR_CYC = TMR_W'(ns2cyc(T_WR_NS));
	localparam logic [TMR_W-1:0] XSNR_CYC = TMR_W'(ns2cyc(T_XSNR_NS));
	localparam logic [TMR_W-1:0] BURST_CYC = TMR_W'(BL / 2);
	localparam logic [TMR_W-1:0] WBURST_CYC = TMR_W'(WL_CYC + BL / 2);
	localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;

	// =========================================================
	// Decoded commands (row, column, write strobes, low active)
	typedef enum logic [2:0] {
		CMD_MRS = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR = 3'h4,
		CMD_RD = 3'h5,
		CMD_RSV = 3'h6,
		CMD_NOP = 3'h7
	} sbsc_cmd_type;

	// Per-bank state
	typedef enum logic [2:0] {
		BK_IDLE = 3'h0,
		BK_ACTIVATING = 3'h1,
		BK_ACTIVE = 3'h2,
		BK_READ = 3'h3,
		BK_WRITE = 3'h4,
		BK_READ_AP = 3'h5,
		BK_WRITE_AP = 3'h6,
		BK_PRECHARGING = 3'h7
	} sbsc_bank_type;

	// Whole-device state
	typedef enum logic [2:0] {
		GL_RUN = 3'h0,
		GL_REFRESH = 3'h1,
		GL_MODE_REG = 3'h2,
		GL_PRE_ALL = 3'h3,
		GL_SELF_REF = 3'h4,
		GL_EXIT_WAIT = 3'h5
	} sbsc_glob_type;

endpackage : sbsc_pkg
`default_nettype wire

// ---- design/sbsc_sync.sv ----
// Three-stage synchroniser that passes a change once two stages agree
`timescale 1ns/1ps
`default_nettype none
module sbsc_sync #(
	parameter int WIDTH = 1
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Foreign levels in, settled levels out
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] q
);
	import sbsc_pkg::*;

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

	// Stage chain; first stage feeds only the second
	always_ff @(posedge clk)
	begin
		s1_q <= din;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	// Take a bit only where the last two stages agree
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= (agree & s3_q) | (~agree & q);
	end

endmodule : sbsc_sync
`default_nettype wire

// ---- design/sbsc_top.sv ----
// Bank state and command legality tracker on the SDRAM command pins
`timescale 1ns/1ps
`default_nettype none
module sbsc_top (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Link clock and command pins
	input wire logic link_clk,
	input wire logic cke_n,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [sbsc_pkg::BA_W-1:0] bank_addr,
	input wire logic addr_ap,
	input wire logic [3:0] byte_write_mask,
	// Status in the core clock domain
	output logic [sbsc_pkg::NUM_BANKS-1:0] bank_idle,
	output logic [sbsc_pkg::NUM_BANKS-1:0] bank_open,
	output logic all_idle,
	output logic self_refresh,
	output logic illegal_pulse
);
	import sbsc_pkg::*;

	// =========================================================
	// Reset carried into the link domain
	logic lrst_s1_q;
	logic lrst_s2_q;
	logic lrst_s3_q;
	logic link_rst_n_q;

	// Three stages; take the level once the last two agree
	always_ff @(posedge link_clk)
	begin
		lrst_s1_q <= reset_n;
		lrst_s2_q <= lrst_s1_q;
		lrst_s3_q <= lrst_s2_q;
		if (lrst_s2_q == lrst_s3_q)
			link_rst_n_q <= lrst_s3_q;
	end

	// =========================================================
	// Command decode
	sbsc_cmd_type cmd;
	logic cke_prev_q;
	sbsc_glob_type glob_q;
	sbsc_glob_type glob_d;
	logic [TMR_W-1:0] gtmr_q;
	logic [TMR_W-1:0] gtmr_d;

	assign cmd = sbsc_cmd_type'({ras_n, cas_n, we_n});
	wire selected = !cs_n && cmd != CMD_NOP;
	wire live = !cke_prev_q && !cke_n;
	wire issue = live && selected;
	wire bank_cmd = cmd == CMD_ACT || cmd == CMD_RD || cmd == CMD_WR ||
		(cmd == CMD_PRE && !addr_ap);
	wire pre_all_cmd = cmd == CMD_PRE && addr_ap;
	wire gdone = gtmr_q == TMR_ZERO;

	// =========================================================
	// Banks
	sbsc_bank_type bstate [NUM_BANKS];
	logic [NUM_BANKS-1:0] b_ok;
	logic [NUM_BANKS-1:0] b_pre_ok;
	logic [NUM_BANKS-1:0] b_idle;
	logic [NUM_BANKS-1:0] b_open;
	logic [NUM_BANKS-1:0] b_hit;
	logic pre_all_go;

	wire run = glob_q == GL_RUN;
	wire banks_idle = &b_idle;
	wire tgt_ok = b_ok[bank_addr];
	// Bank command accepted only where its own state allows
	wire bank_go = run && issue && bank_cmd && tgt_ok;
	// Refresh and mode register commands need every bank idle
	wire glob_go = run && issue && (cmd == CMD_REF || cmd == CMD_MRS) && banks_idle;
	assign pre_all_go = run && issue && pre_all_cmd && (&b_pre_ok);
	// Anything else issued while decoding is live is flagged and ignored
	wire illegal = issue && !bank_go && !glob_go && !pre_all_go;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++)
		begin : g_bank
			assign b_hit[gi] = bank_go && bank_addr == BA_W'(gi);
			assign b_idle[gi] = bstate[gi] == BK_IDLE;
			assign b_open[gi] = bstate[gi] == BK_ACTIVE;
			sbsc_bank u_bank (
				.link_clk(link_clk),
				.rst_n(link_rst_n_q),
				.cmd_en(b_hit[gi]),
				.cmd(cmd),
				.auto_pre(addr_ap),
				.pre_all(pre_all_go),
				.state_q(bstate[gi]),
				.cmd_ok(b_ok[gi]),
				.pre_ok(b_pre_ok[gi])
			);
		end
	endgenerate

	// =========================================================
	// Whole-device state: refresh, mode register, precharge all, self refresh
	always_comb
	begin
		glob_d = glob_q;
		gtmr_d = gdone ? gtmr_q : gtmr_q - 8'h01;
		unique case (glob_q)
			GL_RUN:
				if (!cke_prev_q && cke_n && !cs_n && cmd == CMD_REF && banks_idle)
					glob_d = GL_SELF_REF;
				else if (glob_go && cmd == CMD_REF)
				begin
					glob_d = GL_REFRESH;
					gtmr_d = RC_CYC - 8'h01;
				end
				else if (glob_go)
				begin
					glob_d = GL_MODE_REG;
					gtmr_d = MRD_CYC - 8'h01;
				end
				else if (pre_all_go)
				begin
					glob_d = GL_PRE_ALL;
					gtmr_d = RP_CYC - 8'h01;
				end
			GL_REFRESH, GL_MODE_REG, GL_PRE_ALL, GL_EXIT_WAIT:
				if (gdone)
					glob_d = GL_RUN;
			GL_SELF_REF:
				if (cke_prev_q && !cke_n)
				begin
					glob_d = GL_EXIT_WAIT;
					gtmr_d = XSNR_CYC - 8'h01;
				end
			default:
				glob_d = GL_RUN;
		endcase
	end

	// Link-domain registers
	logic [NUM_BANKS-1:0] idle_q;
	logic [NUM_BANKS-1:0] open_q;
	logic sref_q;
	logic illegal_tgl_q;

	always_ff @(posedge link_clk)
	begin
		if (!link_rst_n_q)
		begin
			cke_prev_q <= 1'b1;
			glob_q <= GL_RUN;
			gtmr_q <= TMR_ZERO;
		end
		else
		begin
			cke_prev_q <= cke_n;
			glob_q <= glob_d;
			gtmr_q <= gtmr_d;
		end
	end

	// Status for the core side; illegal command sent as a toggle
	// Two refusals on adjacent link edges can cancel in the crossing
	always_ff @(posedge link_clk)
	begin
		if (!link_rst_n_q)
		begin
			idle_q <= '1;
			open_q <= '0;
			sref_q <= 1'b0;
			illegal_tgl_q <= 1'b0;
		end
		else
		begin
			idle_q <= run ? b_idle : '0;
			open_q <= b_open;
			sref_q <= glob_q == GL_SELF_REF || glob_q == GL_EXIT_WAIT;
			illegal_tgl_q <= illegal_tgl_q ^ illegal;
		end
	end

	// =========================================================
	// Crossing into the core domain
	logic [NUM_BANKS-1:0] idle_s;
	logic tgl_s;
	logic tgl_seen_q;

	sbsc_sync #(.WIDTH(NUM_BANKS + NUM_BANKS + 2)) u_sync (
		.clk(core_clk),
		.rst_n(reset_n),
		.din({idle_q, open_q, sref_q, illegal_tgl_q}),
		.q({idle_s, bank_open, self_refresh, tgl_s})
	);

	// Core outputs; one pulse per toggle change that crosses
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			tgl_seen_q <= 1'b0;
			illegal_pulse <= 1'b0;
			bank_idle <= '0;
			all_idle <= 1'b0;
		end
		else
		begin
			tgl_seen_q <= tgl_s;
			illegal_pulse <= tgl_s ^ tgl_seen_q;
			bank_idle <= idle_s;
			all_idle <= &idle_s;
		end
	end

	// =========================================================
	// Checks
	busy_refuse_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		issue && bank_cmd && !tgt_ok |-> !bank_go && illegal)
		else $error("command to a busy bank was accepted");
	refresh_len_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		glob_q == GL_RUN && glob_go && cmd == CMD_REF
		|=> glob_q == GL_REFRESH [*4] ##1 glob_q == GL_RUN)
		else $error("refresh did not last the cycle time");
	mode_reg_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		glob_go && cmd == CMD_MRS |=> glob_q == GL_MODE_REG ##1 glob_q == GL_RUN)
		else $error("mode register access length wrong");
	pre_all_idle_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		pre_all_go |=> (&b_idle) && glob_q == GL_PRE_ALL ##2 glob_q == GL_RUN)
		else $error("precharge all did not idle every bank");
	no_decode_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		(cke_n || cke_prev_q || !run) |-> !bank_go && !glob_go)
		else $error("command accepted outside live decoding");
	exit_wait_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		glob_q == GL_SELF_REF && cke_prev_q && !cke_n
		|=> glob_q == GL_EXIT_WAIT [*8] ##1 glob_q == GL_EXIT_WAIT [*6]
		##1 glob_q == GL_RUN)
		else $error("self refresh exit wait too short");
	decode_act_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		cs_n |-> !issue)
		else $error("deselected cycle decoded as a command");
	nop_decode_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		!cs_n && cmd == CMD_NOP |-> !issue)
		else $error("no-operation decoded as a command");

	// Device-wide states refuse every command and hide bank idle status
	refresh_busy_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		glob_q == GL_REFRESH && issue |-> illegal)
		else $error("command taken during refresh");
	mode_busy_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		glob_q == GL_MODE_REG && issue |-> illegal)
		else $error("command taken during mode register access");
	pre_all_busy_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		glob_q == GL_PRE_ALL && issue |-> illegal)
		else $error("command taken during precharge all");
	idle_hidden_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		glob_q != GL_RUN |=> idle_q == '0)
		else $error("banks shown idle outside normal run");

	// Refusals and acceptance by bank state and device-wide preconditions
	glob_refuse_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		issue && (cmd == CMD_REF || cmd == CMD_MRS) && !banks_idle |-> !glob_go && illegal)
		else $error("device-wide command taken with a bank busy");
	pre_all_refuse_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		issue && pre_all_cmd && !(&b_pre_ok) |-> !pre_all_go && illegal)
		else $error("precharge all taken with a bank not prechargeable");
	idle_act_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		run && issue && cmd == CMD_ACT && bstate[bank_addr] == BK_IDLE |-> bank_go)
		else $error("activate to an idle bank was refused");
	sref_idle_a: assert property (@(posedge link_clk) disable iff (!link_rst_n_q)
		glob_q == GL_RUN && !banks_idle |=> glob_q != GL_SELF_REF)
		else $error("self refresh entered with a bank busy");

	// Core side: a refusal pulse only follows a crossed toggle
	pulse_once_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		illegal_pulse |-> tgl_seen_q != $past(tgl_seen_q))
		else $error("refusal pulse without a toggle");

endmodule : sbsc_top
`default_nettype wire

// ---- verif/sbsc_ctl_model.sv ----
// Memory controller model that drives the SDRAM command pins
`timescale 1ns/1ps
`default_nettype none
module sbsc_ctl_model (
	// Link clock
	input wire logic link_clk,
	// Command pins
	output logic cke_n,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [sbsc_pkg::BA_W-1:0] bank_addr,
	output logic addr_ap,
	output logic [3:0] byte_write_mask
);
	import sbsc_pkg::*;

	// =========================================================
	// Pins at time zero: deselected, enable low for normal decoding
	initial
	begin
		cke_n = 1'b0;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		bank_addr = '0;
		addr_ap = 1'b0;
		byte_write_mask = 4'hf;
	end

	// One command on the next link edge; mask bytes except on writes
	task automatic drive(input logic [2:0] cmd, input logic [BA_W-1:0] ba,
		input logic ap, input logic ck);
		@(posedge link_clk);
		#2;
		cke_n = ck;
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = cmd;
		bank_addr = ba;
		addr_ap = ap;
		byte_write_mask = (cmd == 3'h4) ? 4'h0 : 4'hf;
	endtask : drive

	// Deselect; strobes and address flip so no stale command lingers
	task automatic release_pins();
		@(posedge link_clk);
		#2;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
		bank_addr = ~bank_addr;
		addr_ap = ~addr_ap;
	endtask : release_pins
endmodule : sbsc_ctl_model
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the SDRAM bank state tracker
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sbsc_pkg::*;
	typedef struct {logic [2:0] cmd; logic [BA_W-1:0] ba; logic ap;
		logic [NUM_BANKS-1:0] idle; logic [NUM_BANKS-1:0] open; int ill;} sbsc_row_type;
	localparam logic [2:0] C_ACT = 3'h3, C_RD = 3'h5, C_WR = 3'h4;
	localparam logic [2:0] C_PRE = 3'h2, C_REF = 3'h1, C_MRS = 3'h0, C_NOP = 3'h7;
	logic core_clk, reset_n, link_clk, cke_n, cs_n, ras_n, cas_n, we_n, addr_ap;
	logic all_idle, self_refresh, illegal_pulse;
	logic [BA_W-1:0] bank_addr;
	logic [3:0] byte_write_mask;
	logic [NUM_BANKS-1:0] bank_idle, bank_open;
	int n_mismatch = 0;
	int compares = 0;
	int n_ill = 0;
	int exp_ill = 0;
	sbsc_row_type rows [12];

	// =========================================================
	// Clocks, unrelated in phase
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	sbsc_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
		.cke_n(cke_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_addr(bank_addr), .addr_ap(addr_ap), .byte_write_mask(byte_write_mask),
		.bank_idle(bank_idle), .bank_open(bank_open), .all_idle(all_idle),
		.self_refresh(self_refresh), .illegal_pulse(illegal_pulse));
	sbsc_ctl_model i_ctl (.link_clk(link_clk), .cke_n(cke_n), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr),
		.addr_ap(addr_ap), .byte_write_mask(byte_write_mask));

	// Count refusal pulses
	always @(posedge core_clk)
		if (illegal_pulse === 1'b1)
			n_ill++;

	// =========================================================
	// Compare and report
	task automatic end_of_test();
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	task automatic cmp8(input string nm, input logic [NUM_BANKS-1:0] e, g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : cmp8

	task automatic cmpn(input string nm, input int e, g);
		compares++;
		if (g != e)
		begin
			n_mismatch++;
			$display("BAD %s exp %0d got %0d", nm, e, g);
		end
	endtask : cmpn

	// Bounded wait for the status to settle, then compare
	task automatic wait_st(input logic [NUM_BANKS-1:0] idle, open, input logic sr);
		int k;
		for (k = 0; k < 80; k++)
		begin
			if (bank_idle === idle && bank_open === open && all_idle === &idle
				&& self_refresh === sr)
				break;
			@(posedge core_clk);
		end
		if (k == 80)
		begin
			n_mismatch++;
			$display("BAD status_wait exp %h got %h", idle, bank_idle);
			end_of_test();
		end
		cmp8("bank_idle", idle, bank_idle);
		cmp8("bank_open", open, bank_open);
	endtask : wait_st

	// Let any refusal pulse cross, then check the count
	task automatic settle_ill(input int add);
		repeat (12) @(posedge core_clk);
		exp_ill += add;
		cmpn("illegal_count", exp_ill, n_ill);
	endtask : settle_ill

	task automatic do_reset();
		@(posedge core_clk);
		#2;
		reset_n = 1'b0;
		repeat (10) @(posedge core_clk);
		cmp8("idle_in_reset", 8'h00, bank_idle);
		cmp8("open_in_reset", 8'h00, bank_open);
		cmp8("flags_in_reset", 8'h00, {5'h00, all_idle, self_refresh, illegal_pulse});
		#2;
		reset_n = 1'b1;
		wait_st(8'hff, 8'h00, 1'b0);
		repeat (6) @(posedge link_clk);
	endtask : do_reset

	initial
	begin
		#1000000;
		n_mismatch++;
		end_of_test();
	end

	// =========================================================
	// Main sequence
	initial
	begin
		reset_n = 1'b0;
		rows = '{'{C_ACT, 0, 0, 8'hfe, 8'h01, 0},
			'{C_ACT, 1, 0, 8'hfc, 8'h03, 0},
			'{C_RD, 0, 0, 8'hfc, 8'h03, 0},
			'{C_WR, 1, 1, 8'hfe, 8'h01, 0},
			'{C_WR, 0, 0, 8'hfe, 8'h01, 0},
			'{C_PRE, 0, 0, 8'hff, 8'h00, 0},
			'{C_REF, 0, 0, 8'hff, 8'h00, 0},
			'{C_MRS, 0, 0, 8'hff, 8'h00, 0},
			'{C_RD, 2, 0, 8'hff, 8'h00, 1},
			'{C_ACT, 7, 0, 8'h7f, 8'h80, 0},
			'{C_REF, 0, 0, 8'h7f, 8'h80, 1},
			'{C_PRE, 0, 1, 8'hff, 8'h00, 0}};
		do_reset();
		foreach (rows[i])
		begin
			i_ctl.drive(rows[i].cmd, rows[i].ba, rows[i].ap, 1'b0);
			i_ctl.release_pins();
			settle_ill(rows[i].ill);
			wait_st(rows[i].idle, rows[i].open, 1'b0);
		end
		// Same-bank read while activating is refused, other bank taken
		i_ctl.drive(C_ACT, 4, 0, 1'b0);
		i_ctl.drive(C_RD, 4, 0, 1'b0);
		i_ctl.drive(C_ACT, 5, 0, 1'b0);
		i_ctl.release_pins();
		settle_ill(1);
		wait_st(8'hcf, 8'h30, 1'b0);
		// Auto precharge read blocks its bank, other bank precharges
		i_ctl.drive(C_RD, 4, 1, 1'b0);
		i_ctl.drive(C_ACT, 4, 0, 1'b0);
		i_ctl.drive(C_PRE, 5, 0, 1'b0);
		i_ctl.release_pins();
		settle_ill(1);
		wait_st(8'hff, 8'h00, 1'b0);
		// Refresh must not be interrupted
		i_ctl.drive(C_REF, 0, 0, 1'b0);
		i_ctl.drive(C_ACT, 0, 0, 1'b0);
		i_ctl.release_pins();
		settle_ill(1);
		wait_st(8'hff, 8'h00, 1'b0);
		// Mode register access and precharge all refuse the next command
		i_ctl.drive(C_MRS, 0, 0, 1'b0);
		i_ctl.drive(C_ACT, 1, 0, 1'b0);
		i_ctl.release_pins();
		settle_ill(1);
		wait_st(8'hff, 8'h00, 1'b0);
		i_ctl.drive(C_PRE, 0, 1, 1'b0);
		i_ctl.drive(C_ACT, 1, 0, 1'b0);
		i_ctl.release_pins();
		settle_ill(1);
		wait_st(8'hff, 8'h00, 1'b0);
		// Precharge all refused while a bank is still activating
		i_ctl.drive(C_ACT, 2, 0, 1'b0);
		i_ctl.drive(C_PRE, 0, 1, 1'b0);
		i_ctl.release_pins();
		settle_ill(1);
		wait_st(8'hfb, 8'h04, 1'b0);
		i_ctl.drive(C_PRE, 2, 0, 1'b0);
		i_ctl.release_pins();
		settle_ill(0);
		wait_st(8'hff, 8'h00, 1'b0);
		// Self refresh, then a command inside the exit wait is refused
		i_ctl.drive(C_REF, 0, 0, 1'b1);
		i_ctl.release_pins();
		wait_st(8'h00, 8'h00, 1'b1);
		i_ctl.drive(C_NOP, 0, 0, 1'b0);
		i_ctl.drive(C_ACT, 3, 0, 1'b0);
		i_ctl.release_pins();
		settle_ill(1);
		wait_st(8'hff, 8'h00, 1'b0);
		i_ctl.drive(C_ACT, 3, 0, 1'b0);
		i_ctl.release_pins();
		settle_ill(0);
		wait_st(8'hf7, 8'h08, 1'b0);
		// Reset in mid-run closes the open row
		do_reset();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
